// *** bhl_pkg.sv ***
// Constants, encodings and carrier types for the byte and halfword load unit
package bhl_pkg;

  // Load-type field encodings
  localparam logic [2:0] LT_HALF_U = 3'h0;
  localparam logic [2:0] LT_BYTE_U = 3'h1;
  localparam logic [2:0] LT_BYTE_S = 3'h2;
  localparam logic [2:0] LT_HALF_S = 3'h4;

  // Address generator options
  localparam logic [2:0] AM_NEG_OFS = 3'h0;
  localparam logic [2:0] AM_POS_OFS = 3'h1;
  localparam logic [2:0] AM_PRE_DEC = 3'h2;
  localparam logic [2:0] AM_PRE_INC = 3'h3;
  localparam logic [2:0] AM_POST_DEC = 3'h4;
  localparam logic [2:0] AM_POST_INC = 3'h5;

  // Offset scaling in bits
  localparam int BYTE_SHIFT = 0;
  localparam int HALF_SHIFT = 1;

  // Defaults when no offset is written
  localparam logic [31:0] DEFAULT_STEP = 32'h0000_0001;
  localparam logic [31:0] DEFAULT_OFFSET = 32'h0000_0000;

  // Registers eligible for circular addressing
  localparam logic [4:0] CIRC_REG_LO = 5'h04;
  localparam logic [4:0] CIRC_REG_HI = 5'h07;

  // Pipeline timing in cycles
  localparam int LOAD_DELAY_SLOTS = 4;
  localparam int MEM_LATENCY = 3;

  // Instruction as issued into the first execute stage
  typedef struct packed {
    logic valid;
    logic cond;
    logic [2:0] ld_type;
    logic long_form;
    logic unit_side;
    logic dst_side;
    logic [2:0] addr_mode;
    logic offset_given;
    logic use_index;
    logic [4:0] base_num;
    logic [4:0] dst_num;
    logic [4:0] short_offset_const;
    logic [14:0] long_offset_const;
  } bhl_instr_t;

  // Register file write port
  typedef struct packed {
    logic we;
    logic side;
    logic [4:0] num;
    logic [31:0] data;
  } bhl_wr_t;

  // Load in flight between execute stages
  typedef struct packed {
    logic valid;
    logic [2:0] ld_type;
    logic [1:0] lane;
    logic side;
    logic [4:0] num;
  } bhl_stage_t;

endpackage : bhl_pkg

// *** bhl_addr_gen.sv ***
// Effective address and base pointer update for byte and halfword loads
`timescale 1ns/100ps
`default_nettype none
module bhl_addr_gen
  import bhl_pkg::*;
(
  input wire bhl_instr_t instr, // Issued instruction
  input wire logic [31:0] base_val, // Base pointer register value
  input wire logic [31:0] index_val, // Index register value
  input wire logic [31:0] gb_first, // First global base register
  input wire logic [31:0] gb_second, // Second global base register
  input wire logic [7:0] circ_sel, // Circular enables, side B in top nibble
  input wire logic [4:0] circ_size, // Circular block size code
  output logic [31:0] eff_addr, // Address sent to memory
  output logic [31:0] new_base, // Updated base pointer
  output logic base_upd, // Base pointer is modified
  output logic circ_on // Circular arithmetic in use
);

  logic is_half;
  logic is_post;
  logic is_modify;
  logic is_sub;
  logic in_circ_range;
  logic [31:0] raw_ofs;
  logic [31:0] short_ofs;
  logic [31:0] scaled;
  logic [31:0] base_sel;
  logic [31:0] lin;
  logic [31:0] mask;
  logic [31:0] result;

  // Option decode
  assign is_half = (instr.ld_type == LT_HALF_S) || (instr.ld_type == LT_HALF_U);
  assign is_post = (instr.addr_mode == AM_POST_INC) || (instr.addr_mode == AM_POST_DEC);
  assign is_modify = is_post || (instr.addr_mode == AM_PRE_INC) || (instr.addr_mode == AM_PRE_DEC);
  assign is_sub = !instr.long_form && ((instr.addr_mode == AM_NEG_OFS) ||
                  (instr.addr_mode == AM_PRE_DEC) || (instr.addr_mode == AM_POST_DEC));

  // Offset source, with defaults when none is written
  assign short_ofs = instr.use_index ? index_val : {27'h0, instr.short_offset_const};
  assign raw_ofs = instr.long_form ? {17'h0, instr.long_offset_const} :
                   instr.offset_given ? short_ofs :
                   is_modify ? DEFAULT_STEP : DEFAULT_OFFSET;

  // Scale by element size
  assign scaled = is_half ? (raw_ofs << HALF_SHIFT) : (raw_ofs << BYTE_SHIFT);

  // Base selection, long form uses a global base
  assign base_sel = !instr.long_form ? base_val :
                    instr.unit_side ? gb_second : gb_first;

  // Linear arithmetic
  assign lin = is_sub ? (base_sel - scaled) : (base_sel + scaled);

  // Circular wrap inside a power-of-two block
  assign in_circ_range = (instr.base_num >= CIRC_REG_LO) && (instr.base_num <= CIRC_REG_HI);
  assign circ_on = !instr.long_form && in_circ_range &&
                   circ_sel[{instr.unit_side, instr.base_num[1:0]}];
  assign mask = (32'h0000_0002 << circ_size) - 32'h0000_0001;
  assign result = circ_on ? ((base_sel & ~mask) | (lin & mask)) : lin;

  // Post forms access at the original base
  assign eff_addr = is_post ? base_sel : result;
  assign new_base = result;
  assign base_upd = !instr.long_form && is_modify;

endmodule : bhl_addr_gen
`default_nettype wire

// *** bhl_extend.sv ***
// Lane selection and extension of fetched byte or halfword
`timescale 1ns/100ps
`default_nettype none
module bhl_extend
  import bhl_pkg::*;
(
  input wire logic [31:0] rdata, // Aligned word from memory
  input wire logic [1:0] lane, // Low address bits
  input wire logic [2:0] ld_type, // Load type
  output logic [31:0] value // Extended result
);

  logic [7:0] byte_v;
  logic [15:0] half_v;

  // Little-endian lane pick
  assign byte_v = rdata[{lane, 3'h0} +: 8];
  assign half_v = lane[1] ? rdata[31:16] : rdata[15:0];

  // Extension by load type
  assign value = (ld_type == LT_BYTE_S) ? {{24{byte_v[7]}}, byte_v} :
                 (ld_type == LT_BYTE_U) ? {24'h0, byte_v} :
                 (ld_type == LT_HALF_S) ? {{16{half_v[15]}}, half_v} :
                 {16'h0, half_v};

endmodule : bhl_extend
`default_nettype wire

// *** bhl_unit.sv ***
// Byte and halfword load execution unit, execute stages one to five
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Byte loads add or subtract the offset unshifted.
// - Halfword loads shift the offset left one bit first.
// - Pre and offset forms access the sum; post forms access the old base.
// - Type 010 is signed byte, 001 is zero-extended byte.
// - Type 100 is signed halfword, 000 is zero-extended halfword.
// - Linear by default; registers 4 to 7 may wrap circularly if enabled.
// - Byte fills low 8 bits; upper 24 sign-extended or cleared.
// - Halfword fills low 16 bits; upper 16 sign-extended or cleared.
// - Destination file select 0 writes file A, 1 writes file B.
// - Unit select 0 uses side A unit and file, 1 side B.
// - Without an offset, steps are 1 and offsets are 0.
// - Loaded value written four cycles later; base update immediately.
// - Long form runs on side B with first or second global base.
// - Long form only adds and is always linear.
// - Long constant shifted 0 for bytes and 1 for halfwords.
module bhl_unit
  import bhl_pkg::*;
(
  input wire logic CLK, // Clock, 25 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire bhl_instr_t INSTR, // Instruction entering execute
  input wire logic [31:0] BASE_VAL, // Base pointer register read
  input wire logic [31:0] INDEX_VAL, // Index register read
  input wire logic [31:0] GLOBAL_BASE_FIRST, // First global base value
  input wire logic [31:0] GLOBAL_BASE_SECOND, // Second global base value
  input wire logic [7:0] CIRC_SEL, // Circular enables per register
  input wire logic [4:0] CIRC_SIZE, // Circular block size code
  input wire logic [31:0] MEM_RDATA, // Read word from memory
  output logic MEM_REQ, // Memory load request
  output logic [31:0] MEM_ADDR, // Memory byte address
  output logic MEM_HALF, // Access is a halfword
  output logic MEM_UNIT_B, // Issued by side B data unit
  output bhl_wr_t BASE_WR, // Base pointer write port
  output bhl_wr_t DST_WR // Destination write port
);

  // Load type decode, shared by issue and checks
  function automatic logic type_legal(input logic [2:0] t);
    type_legal = (t == LT_BYTE_S) || (t == LT_BYTE_U) || (t == LT_HALF_S) || (t == LT_HALF_U);
  endfunction : type_legal

  function automatic logic type_half(input logic [2:0] t);
    type_half = (t == LT_HALF_S) || (t == LT_HALF_U);
  endfunction : type_half

  logic issue;
  logic [31:0] eff_addr;
  logic [31:0] new_base;
  logic base_upd;
  logic circ_on;
  logic [31:0] ext_value;
  logic unit_b;
  bhl_stage_t stage_d;
  bhl_stage_t pipe_q [1:LOAD_DELAY_SLOTS];
  logic mem_req_q;
  logic [31:0] mem_addr_q;
  logic mem_half_q;
  logic mem_unit_b_q;
  bhl_wr_t base_wr_q;
  bhl_wr_t base_wr_d;
  bhl_wr_t dst_wr_q;
  bhl_wr_t dst_wr_d;
  logic [2:0] dst_type_q;

  // Issue qualification
  assign issue = INSTR.valid && INSTR.cond && type_legal(INSTR.ld_type);
  assign unit_b = INSTR.long_form ? 1'b1 : INSTR.unit_side;

  // Address generation
  bhl_addr_gen u_addr_gen (
    .instr(INSTR),
    .base_val(BASE_VAL),
    .index_val(INDEX_VAL),
    .gb_first(GLOBAL_BASE_FIRST),
    .gb_second(GLOBAL_BASE_SECOND),
    .circ_sel(CIRC_SEL),
    .circ_size(CIRC_SIZE),
    .eff_addr(eff_addr),
    .new_base(new_base),
    .base_upd(base_upd),
    .circ_on(circ_on)
  );

  // Base pointer write, into the executing unit's file
  assign base_wr_d.we = issue && base_upd;
  assign base_wr_d.side = INSTR.unit_side;
  assign base_wr_d.num = INSTR.base_num;
  assign base_wr_d.data = new_base;

  // Stage one record
  assign stage_d.valid = issue;
  assign stage_d.ld_type = INSTR.ld_type;
  assign stage_d.lane = eff_addr[1:0];
  assign stage_d.side = INSTR.dst_side;
  assign stage_d.num = INSTR.dst_num;

  // First execute stage registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= 32'h0;
      mem_half_q <= 1'b0;
      mem_unit_b_q <= 1'b0;
      base_wr_q <= '0;
      pipe_q[1] <= '0;
    end else begin
      mem_req_q <= issue;
      mem_addr_q <= eff_addr;
      mem_half_q <= type_half(INSTR.ld_type);
      mem_unit_b_q <= unit_b;
      base_wr_q <= base_wr_d;
      pipe_q[1] <= stage_d;
    end
  end

  // Later stages carry the load toward write-back
  genvar gi;
  generate
    for (gi = 2; gi <= LOAD_DELAY_SLOTS; gi++) begin : g_pipe
      always_ff @(posedge CLK) begin
        if (RST) begin
          pipe_q[gi] <= '0;
        end else begin
          pipe_q[gi] <= pipe_q[gi-1];
        end
      end
    end
  endgenerate

  // Extension of the returned word
  bhl_extend u_extend (
    .rdata(MEM_RDATA),
    .lane(pipe_q[LOAD_DELAY_SLOTS].lane),
    .ld_type(pipe_q[LOAD_DELAY_SLOTS].ld_type),
    .value(ext_value)
  );

  // Destination write in the fifth stage
  assign dst_wr_d.we = pipe_q[LOAD_DELAY_SLOTS].valid;
  assign dst_wr_d.side = pipe_q[LOAD_DELAY_SLOTS].side;
  assign dst_wr_d.num = pipe_q[LOAD_DELAY_SLOTS].num;
  assign dst_wr_d.data = ext_value;

  // Write-back register
  always_ff @(posedge CLK) begin
    if (RST) begin
      dst_wr_q <= '0;
      dst_type_q <= LT_HALF_U;
    end else begin
      dst_wr_q <= dst_wr_d;
      dst_type_q <= pipe_q[LOAD_DELAY_SLOTS].ld_type;
    end
  end

  // Outputs straight from flops
  assign MEM_REQ = mem_req_q;
  assign MEM_ADDR = mem_addr_q;
  assign MEM_HALF = mem_half_q;
  assign MEM_UNIT_B = mem_unit_b_q;
  assign BASE_WR = base_wr_q;
  assign DST_WR = dst_wr_q;

  // Checks on the unit's own outputs
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_false_pred_nop: assert property (
    (INSTR.valid && !INSTR.cond) |=> (!MEM_REQ && !BASE_WR.we) ##4 !DST_WR.we)
    else $error("false predicate produced activity");

  a_issue_req: assert property (
    (INSTR.valid && INSTR.cond && (INSTR.ld_type == LT_BYTE_S || INSTR.ld_type == LT_BYTE_U))
    |=> MEM_REQ && !MEM_HALF)
    else $error("byte load not issued as byte");

  a_half_req: assert property (
    (INSTR.valid && INSTR.cond && (INSTR.ld_type == LT_HALF_S || INSTR.ld_type == LT_HALF_U))
    |=> MEM_REQ && MEM_HALF)
    else $error("halfword load not issued as halfword");

  a_dst_four_slots: assert property (
    MEM_REQ |-> ##4 DST_WR.we)
    else $error("destination not written four cycles after request");

  a_base_zero_slot: assert property (
    (issue && !INSTR.long_form && INSTR.addr_mode >= AM_PRE_DEC && INSTR.addr_mode <= AM_POST_INC)
    |=> BASE_WR.we && MEM_REQ)
    else $error("base update not alongside request");

  a_byte_pos_ofs: assert property (
    (issue && !INSTR.long_form && !circ_on && INSTR.use_index && INSTR.offset_given &&
     INSTR.addr_mode == AM_POS_OFS && !type_half(INSTR.ld_type))
    |=> MEM_ADDR == $past(BASE_VAL) + $past(INDEX_VAL))
    else $error("byte offset was scaled");

  a_half_neg_ofs: assert property (
    (issue && !INSTR.long_form && !circ_on && INSTR.use_index && INSTR.offset_given &&
     INSTR.addr_mode == AM_NEG_OFS && type_half(INSTR.ld_type))
    |=> MEM_ADDR == $past(BASE_VAL) - {$past(INDEX_VAL[30:0]), 1'b0})
    else $error("halfword offset not shifted by one");

  a_post_old_base: assert property (
    (issue && !INSTR.long_form &&
     (INSTR.addr_mode == AM_POST_INC || INSTR.addr_mode == AM_POST_DEC))
    |=> MEM_ADDR == $past(BASE_VAL))
    else $error("post form did not use original base");

  a_long_form_b: assert property (
    (issue && INSTR.long_form && INSTR.unit_side && !type_half(INSTR.ld_type))
    |=> MEM_UNIT_B && !BASE_WR.we &&
        MEM_ADDR == $past(GLOBAL_BASE_SECOND) + {17'h0, $past(INSTR.long_offset_const)})
    else $error("long byte form address or side wrong");

  a_long_half_add: assert property (
    (issue && INSTR.long_form && !INSTR.unit_side && type_half(INSTR.ld_type))
    |=> MEM_ADDR == $past(GLOBAL_BASE_FIRST) + {16'h0, $past(INSTR.long_offset_const), 1'b0})
    else $error("long halfword form not added shifted");

  a_byte_extend: assert property (
    (DST_WR.we && (dst_type_q == LT_BYTE_S || dst_type_q == LT_BYTE_U))
    |-> DST_WR.data[31:8] == ((dst_type_q == LT_BYTE_S && DST_WR.data[7]) ? 24'hff_ffff : 24'h0))
    else $error("byte extension wrong");

  a_half_extend: assert property (
    (DST_WR.we && (dst_type_q == LT_HALF_S || dst_type_q == LT_HALF_U))
    |-> DST_WR.data[31:16] == ((dst_type_q == LT_HALF_S && DST_WR.data[15]) ? 16'hffff : 16'h0))
    else $error("halfword extension wrong");

  a_dst_file: assert property (
    (issue && INSTR.dst_side) |-> ##5 (DST_WR.we && DST_WR.side))
    else $error("destination file select lost");

  a_unit_side: assert property (
    (issue && !INSTR.long_form) |=> (MEM_UNIT_B == $past(INSTR.unit_side)) &&
      (!BASE_WR.we || BASE_WR.side == $past(INSTR.unit_side)))
    else $error("unit side routing wrong");

  a_default_step: assert property (
    (issue && !INSTR.long_form && !circ_on && !INSTR.offset_given &&
     INSTR.addr_mode == AM_PRE_INC && !type_half(INSTR.ld_type))
    |=> BASE_WR.data == $past(BASE_VAL) + 32'h1 && MEM_ADDR == BASE_WR.data)
    else $error("default step not one");

  a_linear_default: assert property (
    (issue && !(INSTR.base_num >= CIRC_REG_LO && INSTR.base_num <= CIRC_REG_HI)) |-> !circ_on)
    else $error("circular mode outside eligible registers");

  a_type_refused: assert property (
    (INSTR.valid && INSTR.cond && !type_legal(INSTR.ld_type)) |=> !MEM_REQ && !BASE_WR.we)
    else $error("unknown load type produced activity");

  a_long_no_update: assert property (
    (issue && INSTR.long_form) |=> MEM_UNIT_B && !BASE_WR.we)
    else $error("long form touched the base pointer");

  c_byte_load: cover property (issue && INSTR.ld_type == LT_BYTE_S ##5 DST_WR.we);
  c_half_post: cover property (issue && INSTR.addr_mode == AM_POST_INC &&
    type_half(INSTR.ld_type));
  c_circ_wrap: cover property (issue && circ_on && base_upd);
  c_long_form: cover property (issue && INSTR.long_form ##1 MEM_REQ);

endmodule : bhl_unit
`default_nettype wire

// *** bhl_unit_dummy_guard.sv ***
// Intentionally empty companion file
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** bhl_mem_model.sv ***
// Data memory model answering loads three cycles after each request
`timescale 1ns/100ps
`default_nettype none
module bhl_mem_model (
  input wire logic clk, // Clock
  input wire logic mem_req, // Load request pulse
  input wire logic [31:0] mem_addr, // Byte address
  output logic [31:0] mem_rdata // Read word
);
  logic [2:0] vld_q = 3'h0;
  logic [31:0] a0_q = 32'h0;
  logic [31:0] a1_q = 32'h0;
  logic [31:0] a2_q = 32'h0;
  logic tog_q = 1'b0;
  // Requests walk toward the answer cycle
  always_ff @(posedge clk) begin
    vld_q <= {vld_q[1:0], mem_req};
    a0_q <= mem_addr;
    a1_q <= a0_q;
    a2_q <= a1_q;
    tog_q <= ~tog_q;
  end
  // Address-dependent word; changing junk outside the answer cycle
  assign mem_rdata = vld_q[2] ? {~a2_q[9:2], a2_q[9:2] ^ 8'h5a, a2_q[9:2], 8'hc3}
                              : (tog_q ? 32'h5555_aaaa : 32'haaaa_5555);
endmodule : bhl_mem_model
`default_nettype wire

// *** tb_byte_half_load_unit.sv ***
// Self-checking bench for the byte and halfword load unit
`timescale 1ns/100ps
`default_nettype none
module tb_byte_half_load_unit;
  import bhl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bhl_instr_t instr = '0;
  logic [31:0] base_val = 32'h0;
  logic [31:0] index_val = 32'h0;
  logic [31:0] gb_first = 32'h0000_4000;
  logic [31:0] gb_second = 32'h0008_0000;
  logic [7:0] circ_sel = 8'h00;
  logic [4:0] circ_size = 5'h03;
  logic [31:0] mem_rdata, mem_addr;
  logic mem_req, mem_half, mem_unit_b;
  bhl_wr_t base_wr, dst_wr;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  bhl_unit dut (.CLK(clk), .RST(rst), .INSTR(instr), .BASE_VAL(base_val),
    .INDEX_VAL(index_val), .GLOBAL_BASE_FIRST(gb_first), .GLOBAL_BASE_SECOND(gb_second),
    .CIRC_SEL(circ_sel), .CIRC_SIZE(circ_size), .MEM_RDATA(mem_rdata), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_HALF(mem_half), .MEM_UNIT_B(mem_unit_b), .BASE_WR(base_wr),
    .DST_WR(dst_wr));
  bhl_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic bhl_instr_t mk(input logic [2:0] t, input logic lf, y, s,
    input logic [2:0] am, input logic og, ui, input logic [4:0] bn, c5, input logic [14:0] c15);
    mk = {1'b1, 1'b1, t, lf, y, s, am, og, ui, bn, bn ^ 5'h10, c5, c15};
  endfunction : mk

  // Expected destination value from the memory model's word pattern
  function automatic logic [31:0] ext_val(input logic [31:0] a, input logic [2:0] t);
    logic [31:0] w;
    logic [7:0] b;
    logic [15:0] h;
    w = {~a[9:2], a[9:2] ^ 8'h5a, a[9:2], 8'hc3};
    b = w[a[1:0] * 8 +: 8];
    h = a[1] ? w[31:16] : w[15:0];
    case (t)
      LT_BYTE_S: ext_val = {{24{b[7]}}, b};
      LT_BYTE_U: ext_val = {24'h000000, b};
      LT_HALF_S: ext_val = {{16{h[15]}}, h};
      default: ext_val = {16'h0000, h};
    endcase
  endfunction : ext_val

  // One load, checked at request, the cycle before write-back, and the write-back cycle
  task automatic run_load(input bhl_instr_t i, input logic [31:0] b, x, ea,
    input logic bwe, input logic [31:0] nb);
    @(posedge clk);
    instr <= i;
    base_val <= b;
    index_val <= x;
    @(posedge clk);
    instr <= '0;
    #1 chk(mem_req, 1'b1);
    chk(mem_addr, ea);
    chk(mem_half, i.ld_type == LT_HALF_S || i.ld_type == LT_HALF_U);
    chk(mem_unit_b, i.long_form | i.unit_side);
    chk(base_wr.we, bwe);
    if (bwe) chk({base_wr.side, base_wr.num, base_wr.data}, {i.unit_side, i.base_num, nb});
    repeat (3) @(posedge clk);
    #1 chk(dst_wr.we, 1'b0);
    @(posedge clk);
    #1 chk(dst_wr.we, 1'b1);
    chk({dst_wr.side, dst_wr.num}, {i.dst_side, i.dst_num});
    chk(dst_wr.data, ext_val(ea, i.ld_type));
  endtask : run_load

  // All four load types, added and subtracted offsets, constant and index
  task automatic t_types();
    logic [2:0] tl [4];
    logic [31:0] b, e;
    logic [4:0] c;
    bhl_instr_t w;
    tl = '{LT_BYTE_S, LT_BYTE_U, LT_HALF_S, LT_HALF_U};
    for (int i = 0; i < 4; i++) begin
      b = 32'h100 + 32'(i) * 32'h24;
      c = 5'(i * 4 + i / 2);
      e = (i < 2) ? b + 32'(c) : b - {26'h0, c, 1'b0};
      w = mk(tl[i], 0, 0, 1, (i < 2) ? AM_POS_OFS : AM_NEG_OFS, 1, i[0], 5'h02, c, 0);
      run_load(w, b, 32'(c), e, 0, 0);
    end
  endtask : t_types

  // Every address generator option, halfword index on side B
  task automatic t_modes();
    logic [31:0] lin;
    bhl_instr_t w;
    for (int m = 0; m < 6; m++) begin
      lin = (m == 0 || m == 2 || m == 4) ? 32'h1f6 : 32'h20a;
      w = mk(LT_HALF_S, 0, 1, 0, 3'(m), 1, 1, 5'h03, 0, 0);
      run_load(w, 32'h200, 32'h5, (m >= 4) ? 32'h200 : lin, m >= 2, lin);
    end
  endtask : t_modes

  // No offset written: step of one element, offset of zero
  task automatic t_defaults();
    bhl_instr_t w;
    w = mk(LT_HALF_U, 0, 0, 0, AM_POST_INC, 0, 0, 5'h01, 5'h1f, 0);
    run_load(w, 32'h300, 0, 32'h300, 1, 32'h302);
    w = mk(LT_BYTE_U, 0, 1, 1, AM_PRE_DEC, 0, 1, 5'h02, 0, 0);
    run_load(w, 32'h300, 32'h9, 32'h2ff, 1, 32'h2ff);
    w = mk(LT_BYTE_S, 0, 0, 1, AM_POS_OFS, 0, 0, 5'h0a, 5'h07, 0);
    run_load(w, 32'h300, 0, 32'h300, 0, 0);
    w = mk(LT_BYTE_S, 0, 0, 1, AM_PRE_INC, 0, 0, 5'h01, 5'h1f, 0);
    run_load(w, 32'h300, 0, 32'h301, 1, 32'h301);
  endtask : t_defaults

  // Unit side and destination file selections
  task automatic t_sides();
    bhl_instr_t w;
    for (int k = 0; k < 4; k++) begin
      w = mk(LT_BYTE_U, 0, k[1], k[0], AM_PRE_INC, 1, 0, 5'h0c, 5'h01, 0);
      run_load(w, 32'h400, 0, 32'h401, 1, 32'h401);
    end
  endtask : t_sides

  // Circular wrap only for an enabled register among 4 to 7
  task automatic t_circ();
    bhl_instr_t w;
    w = mk(LT_BYTE_S, 0, 0, 0, AM_PRE_INC, 1, 0, 5'h05, 5'h04, 0);
    @(posedge clk);
    circ_sel <= 8'h02;
    run_load(w, 32'h10e, 0, 32'h102, 1, 32'h102);
    @(posedge clk);
    circ_size <= 5'h02;
    run_load(w, 32'h10e, 0, 32'h10a, 1, 32'h10a);
    w.base_num = 5'h09;
    run_load(w, 32'h10e, 0, 32'h112, 1, 32'h112);
    w.base_num = 5'h05;
    w.unit_side = 1'b1;
    run_load(w, 32'h10e, 0, 32'h112, 1, 32'h112);
  endtask : t_circ

  // Long form: global bases, add only, linear, no base update
  task automatic t_long();
    bhl_instr_t w;
    @(posedge clk);
    circ_sel <= 8'hff;
    w = mk(LT_BYTE_S, 1, 1, 1, AM_NEG_OFS, 1, 0, 5'h05, 0, 15'h7fff);
    run_load(w, 0, 0, 32'h0008_7fff, 0, 0);
    w = mk(LT_HALF_U, 1, 0, 0, AM_PRE_DEC, 1, 1, 5'h05, 0, 15'h7fff);
    run_load(w, 0, 0, 32'h0001_3ffe, 0, 0);
  endtask : t_long

  // False predicate or unknown load type leaves the request and both write enables low
  task automatic t_pred();
    bhl_instr_t i;
    for (int n = 0; n < 2; n++) begin
      i = mk((n == 0) ? LT_BYTE_S : 3'h7, 0, 0, 0, AM_POST_INC, 1, 0, 5'h04, 5'h01, 0);
      i.cond = (n != 0);
      @(posedge clk);
      instr <= i;
      @(posedge clk);
      instr <= '0;
      repeat (6) begin
        #1 chk({mem_req, base_wr.we, dst_wr.we}, 3'h0);
        @(posedge clk);
      end
    end
  endtask : t_pred

  // Two loads on consecutive edges; the second wraps in the B6 circular block
  task automatic t_back();
    @(posedge clk);
    instr <= mk(LT_BYTE_S, 0, 0, 0, AM_POST_INC, 1, 0, 5'h04, 5'h01, 0);
    base_val <= 32'h500;
    @(posedge clk);
    instr <= mk(LT_HALF_S, 0, 1, 1, AM_PRE_DEC, 1, 1, 5'h06, 0, 0);
    base_val <= 32'h600;
    index_val <= 32'h3;
    #1 chk({mem_req, mem_addr, base_wr.data}, {1'b1, 32'h500, 32'h501});
    @(posedge clk);
    instr <= '0;
    #1 chk({mem_req, mem_addr, base_wr.data}, {1'b1, 32'h602, 32'h602});
    repeat (3) @(posedge clk);
    #1 chk({dst_wr.we, dst_wr.data}, {1'b1, ext_val(32'h500, LT_BYTE_S)});
    @(posedge clk);
    #1 chk({dst_wr.we, dst_wr.side, dst_wr.data}, {2'h3, ext_val(32'h602, LT_HALF_S)});
  endtask : t_back

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk({mem_req, mem_addr, dst_wr.we, base_wr.we}, 35'h0);
    t_types();
    t_modes();
    t_defaults();
    t_sides();
    t_circ();
    t_long();
    t_pred();
    t_back();
    complete_run();
  end
endmodule : tb_byte_half_load_unit
`default_nettype wire
